// >>> hdl/supervisor_pkg.sv
// Shared constants for the supervisory watchdog and reset block.
// Assumes a single 10 MHz system clock; all supervisory timing is counted
// in ticks of the selected timebase, never in raw system clocks.
package supervisor_pkg;

  // ----------------------------------------------------------------------
  // System clock and internal oscillator
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 100;
  localparam int OSC_FREQ_HZ    = 10240;
  localparam int OSC_PERIOD_NS  = 1000000000 / OSC_FREQ_HZ;
  // Longest whole number of system clocks inside one oscillator period
  localparam int OSC_DIV_CYCLES = OSC_PERIOD_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // Timing in milliseconds and in timebase ticks
  // ----------------------------------------------------------------------
  localparam int CNT_W           = 15;
  localparam int WD_SHORT_MS     = 100;
  localparam int WD_LONG_MS      = 1600;
  localparam int RST_ACTIVE_MS   = 50;
  localparam int WD_SHORT_TICKS  = WD_SHORT_MS * OSC_FREQ_HZ / 1000;
  localparam int WD_LONG_TICKS   = WD_LONG_MS * OSC_FREQ_HZ / 1000;
  localparam int RST_TICKS       = RST_ACTIVE_MS * OSC_FREQ_HZ / 1000;
  localparam int EXT_NORMAL_CLKS = 1024;
  localparam int EXT_LONG_CLKS   = 4096;
  localparam int EXT_RST_CLKS    = 512;

  // Terminal counts (last tick index) for the timers
  localparam logic [CNT_W-1:0] INT_SHORT_LAST  = CNT_W'(WD_SHORT_TICKS - 1);
  localparam logic [CNT_W-1:0] INT_LONG_LAST   = CNT_W'(WD_LONG_TICKS - 1);
  localparam logic [CNT_W-1:0] INT_RST_LAST    = CNT_W'(RST_TICKS - 1);
  localparam logic [CNT_W-1:0] EXT_NORMAL_LAST = CNT_W'(EXT_NORMAL_CLKS - 1);
  localparam logic [CNT_W-1:0] EXT_LONG_LAST   = CNT_W'(EXT_LONG_CLKS - 1);
  localparam logic [CNT_W-1:0] EXT_RST_LAST    = CNT_W'(EXT_RST_CLKS - 1);

  // ----------------------------------------------------------------------
  // Reset sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_HOLD  = 2'b00,
    ST_DELAY = 2'b01,
    ST_RUN   = 2'b10
  } sup_state_e;

endpackage

// >>> hdl/timebase_tick.sv
// Timebase selection: internal oscillator divider or external clock pin.
// Assumes raw pin inputs from outside the clock domain; the external clock
// must be well below half the system clock rate to be seen edge by edge.
`timescale 1ns/100ps
module timebase_tick
  import supervisor_pkg::*;
#(
  parameter int DIV = OSC_DIV_CYCLES
) (
  // Clock and reset
  input  wire logic clock_in,
  input  wire logic reset_in,
  // Raw pins
  input  wire logic timebase_source_sel_in,
  input  wire logic timebase_pin_in,
  // Mode from the main sequencer
  input  wire logic backup_active_in,
  // Tick and selection state
  output logic      tick_out,
  output logic      ext_mode_out,
  output logic      pin_level_out
);

  // ----------------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------------
  logic [1:0]  sel_sync_q;
  logic [1:0]  pin_sync_q;
  logic        pin_prev_q;
  logic        ext_mode_q;
  logic        pin_level_q;
  logic [15:0] div_q;
  logic        div_end;
  logic        ext_edge;

  // Two stages each; only the second stage is read by logic
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      sel_sync_q <= 2'h3;
      pin_sync_q <= 2'h3;
      pin_prev_q <= 1'b1;
    end else begin
      sel_sync_q <= {sel_sync_q[0], timebase_source_sel_in};
      pin_sync_q <= {pin_sync_q[0], timebase_pin_in};
      pin_prev_q <= pin_sync_q[1];
    end
  end

  // ----------------------------------------------------------------------
  // Mode capture, frozen in backup so the pins are ignored there
  // ----------------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      ext_mode_q  <= 1'b0;
      pin_level_q <= 1'b1;
    end else if (!backup_active_in) begin
      ext_mode_q  <= !sel_sync_q[1];
      pin_level_q <= pin_sync_q[1];
    end
  end

  // Internal oscillator: one tick per oscillator period
  assign div_end = (div_q == 16'(DIV - 1));

  always_ff @(posedge clock_in) begin
    if (reset_in || div_end) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  // Each rising edge of the external clock is one tick
  assign ext_edge      = pin_sync_q[1] && !pin_prev_q;
  assign tick_out      = ext_mode_q ? ext_edge : div_end;
  assign ext_mode_out  = ext_mode_q;
  assign pin_level_out = pin_level_q;

endmodule

// >>> hdl/kick_edge.sv
// Kick input qualifier and transition detector.
// Assumes raw kick and kick-floating indications from the pin front end;
// the floating flag is a digital result of the analog midsupply sense.
`timescale 1ns/100ps
module kick_edge
  import supervisor_pkg::*;
(
  // Clock and reset
  input  wire logic clock_in,
  input  wire logic reset_in,
  // Raw pins
  input  wire logic watchdog_kick_in,
  input  wire logic kick_float_in,
  // Timebase and gating
  input  wire logic tick_in,
  input  wire logic enable_in,
  // Results
  output logic      edge_out,
  output logic      off_out
);

  // ----------------------------------------------------------------------
  // Synchronise, then sample on the timebase
  // ----------------------------------------------------------------------
  logic [1:0] kick_sync_q;
  logic [1:0] float_sync_q;
  logic       kick_tb_q;
  logic       differs;

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      kick_sync_q  <= 2'h0;
      float_sync_q <= 2'h0;
    end else begin
      kick_sync_q  <= {kick_sync_q[0], watchdog_kick_in};
      float_sync_q <= {float_sync_q[0], kick_float_in};
    end
  end

  // Level last seen on a tick; both polarities of change count once
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      kick_tb_q <= 1'b0;
    end else if (tick_in) begin
      kick_tb_q <= kick_sync_q[1];
    end
  end

  assign differs  = kick_sync_q[1] != kick_tb_q;
  assign off_out  = float_sync_q[1];
  assign edge_out = tick_in && enable_in && !float_sync_q[1] && differs;

endmodule

// >>> hdl/supervisor_watchdog_reset.sv
// Supervisory watchdog, reset sequencer, chip-select gate and warnings.
// Assumes the analog comparators are outside: supply-low, early-warning,
// kick-floating and backup indications arrive as digital levels.
//
// How it works
// - Reset pulse when the kick shows no transition within the timeout.
// - After any reset ends, the long timeout applies first.
// - Watchdog counter restarts when reset is released, whatever caused it.
// - Normal timeout takes over after the first kick seen out of reset.
// - Every kick transition, either polarity, restarts the count from zero.
// - A stuck kick gives a reset pulse after every timeout, forever.
// - Floating kick disables the watchdog; fault status stays high.
// - External clock: 1024 normal, 4096 after reset, 512 reset clocks.
// - Internal, pin low: 100 ms normal, 1.6 s after reset, 50 ms reset.
// - Internal, pin high: 1.6 s both timeouts, 50 ms reset.
// - Source select high uses internal oscillator, low uses the pin.
// - Internal timebase is 10.24 kHz; periods are counts of it.
// - Fault status goes low on expiry, high on the next kick.
// - Fault status is high whenever supply is low.
// - Chip-select output follows its input while supply is good.
// - Chip-select output forced high while supply is low.
// - Early warning output low while the warn comparator reports low.
// - Backup mode fixes all outputs to their stated levels.
// - Backup mode ignores kick, chip-select, timebase pins and warn input.
// - Reset held while supply low and for the reset time after.
// - Active-high reset is always the complement of active-low reset.
`timescale 1ns/100ps
module supervisor_watchdog_reset
  import supervisor_pkg::*;
#(
  parameter int OSC_DIV = OSC_DIV_CYCLES
) (
  // Clock and reset
  input  wire logic clock_in,
  input  wire logic reset_in,
  // Analog front end indications
  input  wire logic supply_low_in,
  input  wire logic early_warn_in,
  input  wire logic backup_active_in,
  // Watchdog and timebase pins
  input  wire logic watchdog_kick_in,
  input  wire logic kick_float_in,
  input  wire logic timebase_source_sel_in,
  input  wire logic timebase_pin_in,
  // RAM chip select
  input  wire logic cs_n_in,
  output logic      cs_n_out,
  // Processor outputs
  output logic      reset_n_out,
  output logic      reset_out,
  output logic      supply_low_n_out,
  output logic      backup_active_out,
  output logic      watchdog_fault_n_out,
  output logic      early_warn_n_out
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [1:0]       supply_sync_q;
  logic [1:0]       warn_sync_q;
  logic [1:0]       backup_sync_q;
  logic             supply_low;
  logic             backup_on;
  logic             low_any;
  sup_state_e       state_q;
  sup_state_e       state_d;
  logic [CNT_W-1:0] rst_cnt_q;
  logic [CNT_W-1:0] wd_cnt_q;
  logic [CNT_W-1:0] wd_last;
  logic [CNT_W-1:0] rst_last;
  logic             long_mode_q;
  logic             reset_n_q;
  logic             fault_n_q;
  logic             warn_n_q;
  logic             supply_low_n_q;
  logic             backup_q;
  logic             tick;
  logic             ext_mode;
  logic             pin_level;
  logic             kick;
  logic             kick_off;
  logic             rst_done;
  logic             wd_expire;

  // Pick the terminal count for the watchdog from mode and phase
  function automatic logic [CNT_W-1:0] wd_limit(input logic ext, input logic pin,
                                                input logic long_phase);
    if (ext) begin
      wd_limit = long_phase ? EXT_LONG_LAST : EXT_NORMAL_LAST;
    end else if (long_phase || pin) begin
      wd_limit = INT_LONG_LAST;
    end else begin
      wd_limit = INT_SHORT_LAST;
    end
  endfunction

  // ----------------------------------------------------------------------
  // Front-end synchronisers
  // ----------------------------------------------------------------------
  // Supply low resets to asserted so outputs start safe; backup resets to deasserted
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      supply_sync_q <= 2'h3;
      warn_sync_q   <= 2'h0;
      backup_sync_q <= 2'h0;
    end else begin
      supply_sync_q <= {supply_sync_q[0], supply_low_in};
      warn_sync_q   <= {warn_sync_q[0], early_warn_in};
      backup_sync_q <= {backup_sync_q[0], backup_active_in};
    end
  end

  assign supply_low = supply_sync_q[1];
  assign backup_on  = backup_sync_q[1];
  // Backup only occurs with supply gone, so it is treated as supply low too
  assign low_any    = supply_low || backup_on;

  // ----------------------------------------------------------------------
  // Timebase and kick detection
  // ----------------------------------------------------------------------
  timebase_tick #(
    .DIV (OSC_DIV)
  ) u_timebase (
    .clock_in               (clock_in),
    .reset_in               (reset_in),
    .timebase_source_sel_in (timebase_source_sel_in),
    .timebase_pin_in        (timebase_pin_in),
    .backup_active_in       (backup_on),
    .tick_out               (tick),
    .ext_mode_out           (ext_mode),
    .pin_level_out          (pin_level)
  );

  kick_edge u_kick (
    .clock_in         (clock_in),
    .reset_in         (reset_in),
    .watchdog_kick_in (watchdog_kick_in),
    .kick_float_in    (kick_float_in),
    .tick_in          (tick),
    .enable_in        (!backup_on),
    .edge_out         (kick),
    .off_out          (kick_off)
  );

  // ----------------------------------------------------------------------
  // Reset sequencer
  // ----------------------------------------------------------------------
  // Reset time is 512 ticks in every mode; kept as two names for clarity
  assign rst_last  = ext_mode ? EXT_RST_LAST : INT_RST_LAST;
  assign rst_done  = tick && (rst_cnt_q == rst_last);
  assign wd_last   = wd_limit(ext_mode, pin_level, long_mode_q);
  // Kick wins over expiry in the same tick, so a late kick is never punished
  assign wd_expire = (state_q == ST_RUN) && tick && !kick && !kick_off
                     && (wd_cnt_q == wd_last);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_HOLD: begin
        if (!low_any) begin
          state_d = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (low_any) begin
          state_d = ST_HOLD;
        end else if (rst_done) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (low_any) begin
          state_d = ST_HOLD;
        end else if (wd_expire) begin
          state_d = ST_DELAY;
        end
      end
      default: begin
        state_d = ST_HOLD;
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state_q   <= ST_HOLD;
      reset_n_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      reset_n_q <= (state_d == ST_RUN);
    end
  end

  // Reset active timer runs only while the delay phase lasts
  always_ff @(posedge clock_in) begin
    if (reset_in || state_q != ST_DELAY) begin
      rst_cnt_q <= '0;
    end else if (tick) begin
      rst_cnt_q <= rst_cnt_q + CNT_W'(1);
    end
  end

  // ----------------------------------------------------------------------
  // Watchdog counter and timeout phase
  // ----------------------------------------------------------------------
  // Held at zero through any reset so release starts a fresh period
  always_ff @(posedge clock_in) begin
    if (reset_in || state_q != ST_RUN || kick) begin
      wd_cnt_q <= '0;
    end else if (tick && !kick_off) begin
      wd_cnt_q <= wd_cnt_q + CNT_W'(1);
    end
  end

  // Long phase armed by any reset, left on the first kick after release
  always_ff @(posedge clock_in) begin
    if (reset_in || state_q != ST_RUN) begin
      long_mode_q <= 1'b1;
    end else if (kick) begin
      long_mode_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      fault_n_q      <= 1'b1;
      warn_n_q       <= 1'b1;
      supply_low_n_q <= 1'b0;
      backup_q       <= 1'b0;
    end else begin
      if (low_any || kick_off) begin
        fault_n_q <= 1'b1;
      end else if (wd_expire) begin
        fault_n_q <= 1'b0;
      end else if (kick) begin
        fault_n_q <= 1'b1;
      end
      warn_n_q       <= !backup_on && !warn_sync_q[1];
      supply_low_n_q <= !low_any;
      backup_q       <= backup_on;
    end
  end

  // Chip-select path stays combinational so the RAM sees minimal delay
  assign cs_n_out             = low_any ? 1'b1 : cs_n_in;
  assign reset_n_out          = reset_n_q;
  assign reset_out            = !reset_n_q;
  assign supply_low_n_out     = supply_low_n_q;
  assign backup_active_out    = backup_q;
  assign watchdog_fault_n_out = fault_n_q;
  assign early_warn_n_out     = warn_n_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence expire_seq;
    wd_expire;
  endsequence

  sequence reset_low_seq;
    !reset_n_out && !watchdog_fault_n_out;
  endsequence

  reset_compl_a: assert property (@(posedge clock_in) disable iff (reset_in)
    reset_out == !reset_n_out)
    else $error("active-high reset is not the complement");

  expire_reset_a: assert property (@(posedge clock_in) disable iff (reset_in)
    expire_seq |=> reset_low_seq)
    else $error("expiry did not assert reset and fault");

  cs_gate_a: assert property (@(posedge clock_in) disable iff (reset_in)
    low_any |-> cs_n_out)
    else $error("chip select not blocked while supply low");

  cs_follow_a: assert property (@(posedge clock_in) disable iff (reset_in)
    !low_any |-> cs_n_out == cs_n_in)
    else $error("chip select does not follow its input");

  backup_fixed_a: assert property (@(posedge clock_in) disable iff (reset_in)
    backup_on [*2] |-> !reset_n_out && !supply_low_n_out && backup_active_out
                       && watchdog_fault_n_out && !early_warn_n_out && cs_n_out)
    else $error("backup mode outputs not fixed");

  supply_fault_a: assert property (@(posedge clock_in) disable iff (reset_in)
    supply_low |=> watchdog_fault_n_out)
    else $error("fault status low while supply low");

  float_quiet_a: assert property (@(posedge clock_in) disable iff (reset_in)
    (kick_off && state_q == ST_RUN && !low_any) |=> reset_n_out && watchdog_fault_n_out)
    else $error("watchdog expired while kick floating");

  kick_restart_a: assert property (@(posedge clock_in) disable iff (reset_in)
    (kick && state_q == ST_RUN && !low_any) |=> wd_cnt_q == '0 && watchdog_fault_n_out)
    else $error("kick did not restart the count");

  release_long_a: assert property (@(posedge clock_in) disable iff (reset_in)
    $rose(reset_n_out) |-> long_mode_q && wd_cnt_q == '0)
    else $error("reset release without fresh long timeout");

  reset_hold_a: assert property (@(posedge clock_in) disable iff (reset_in)
    $rose(reset_n_out) |-> $past(rst_cnt_q) == rst_last && !$past(low_any))
    else $error("reset released before reset time elapsed");

  first_kick_a: assert property (@(posedge clock_in) disable iff (reset_in)
    (state_q == ST_RUN && kick && !low_any) |=> !long_mode_q)
    else $error("normal timeout not taken after first kick");

endmodule

// >>> sim/host_model.sv
// Host processor model: drives the kick port and the timebase pin.
// Assumes the bench changes its controls by non-blocking assignment at rising edges.
`timescale 1ns/100ps
module host_model (
  // Clock
  input  wire logic        clock_in,
  // Controls from the bench
  input  wire logic        kick_toggle_in,
  input  wire logic [15:0] kick_period_in,
  input  wire logic        ext_clock_en_in,
  input  wire logic        pin_level_in,
  // Pins toward the supervisor
  output logic             watchdog_kick_out,
  output logic             timebase_pin_out
);
  // ----------------------------------------------------------------
  // Kick port and timebase pin
  // ----------------------------------------------------------------
  logic [15:0] kick_cnt_q;
  logic [1:0]  pin_cnt_q;
  logic        kick_due;

  // Periodic kicking only when a period is set
  assign kick_due = (kick_period_in != 16'h0000) && (kick_cnt_q == kick_period_in);

  initial begin
    watchdog_kick_out = 1'b0;
    timebase_pin_out  = 1'b0;
    kick_cnt_q        = 16'h0001;
    pin_cnt_q         = 2'h0;
  end

  // Port keeps its power-up level until asked, so the long timeout holds
  always @(posedge clock_in) begin
    kick_cnt_q <= (kick_due || kick_period_in == 16'h0000) ? 16'h0001 : kick_cnt_q + 16'h0001;
    if (kick_toggle_in || kick_due) begin  // Period kept below the short timeout
      watchdog_kick_out <= ~watchdog_kick_out;
    end
  end

  // Each clock level is held 4 clocks, above the 3-clock minimum of the pin
  always @(posedge clock_in) begin
    pin_cnt_q <= pin_cnt_q + 2'h1;
    if (!ext_clock_en_in) begin
      timebase_pin_out <= pin_level_in;
    end else if (pin_cnt_q == 2'h3) begin
      timebase_pin_out <= ~timebase_pin_out;
    end
  end
endmodule

// >>> sim/test_supervisor_watchdog_reset.sv
// Self-checking bench for the supervisory watchdog and reset block.
// Assumes the divider shortened to 2 clocks a tick; expected times follow from that.
`timescale 1ns/100ps
module test_supervisor_watchdog_reset;
  import supervisor_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clock_in, reset_in, supply_low, early_warn, backup, kick_float;
  logic        src_sel, cs_n, kick_toggle, ext_en, pin_level, kick, tb_pin;
  logic        cs_n_out, reset_n, reset_hi, supply_low_n, backup_out, fault_n, warn_n;
  logic        found;
  logic [6:0]  outs;
  logic [15:0] kick_per;
  int          num_errors, checked, n;
  typedef struct packed { logic sl, ew, cs, cs_o, ew_n, sl_n; } row_s;
  row_s        rows [5];

  supervisor_watchdog_reset #(.OSC_DIV(2)) u_dut (.clock_in(clock_in), .reset_in(reset_in),
    .supply_low_in(supply_low), .early_warn_in(early_warn), .backup_active_in(backup),
    .watchdog_kick_in(kick), .kick_float_in(kick_float), .timebase_source_sel_in(src_sel),
    .timebase_pin_in(tb_pin), .cs_n_in(cs_n), .cs_n_out(cs_n_out), .reset_n_out(reset_n),
    .reset_out(reset_hi), .supply_low_n_out(supply_low_n), .backup_active_out(backup_out),
    .watchdog_fault_n_out(fault_n), .early_warn_n_out(warn_n));

  host_model u_host (.clock_in(clock_in), .kick_toggle_in(kick_toggle), .kick_period_in(kick_per),
    .ext_clock_en_in(ext_en), .pin_level_in(pin_level), .watchdog_kick_out(kick),
    .timebase_pin_out(tb_pin));
  // All seven outputs in one word for the whole-state checks
  assign outs = {reset_n, reset_hi, supply_low_n, backup_out, fault_n, warn_n, cs_n_out};

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [6:0] seen, input logic [6:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // Sample 1 ns after the edge so registered outputs have landed
  task automatic step(input int k);
    repeat (k) @(posedge clock_in);
    #1;
  endtask
  // Counts edges until the reset output reaches a level; bounded by lim
  task automatic wait_reset(input logic want, input int lim);
    n = 0;
    found = 1'b0;
    while (n < lim && !found) begin
      step(1);
      n++;
      found = (reset_n === want);
    end
  endtask
  task automatic in_range(input int lo, input int hi);
    check(7'(found && n >= lo && n <= hi), 7'h01);
  endtask
  task automatic kick_once();
    @(posedge clock_in);
    kick_toggle <= 1'b1;
    @(posedge clock_in);
    kick_toggle <= 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end
  // Whole run is about 77k cycles; this only cuts a hang short
  initial begin
    #(95000 * 100);
    num_errors++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    num_errors = 0;
    checked = 0;
    {reset_in, supply_low, src_sel, cs_n} = 4'hF;
    {early_warn, backup, kick_float, kick_toggle, ext_en, pin_level} = 6'h00;
    kick_per = 16'h0000;
    rows[0] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    rows[1] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    rows[2] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
    rows[3] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
    rows[4] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    step(1);
    check(outs, 7'h27);
    @(posedge clock_in);
    reset_in <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      @(posedge clock_in);
      {supply_low, early_warn, cs_n} <= {rows[i].sl, rows[i].ew, rows[i].cs};
      step(6);
      check(7'({cs_n_out, warn_n, supply_low_n}), 7'(rows[i][2:0]));
    end
    @(posedge clock_in);
    cs_n <= 1'b1;
    #1;
    check(7'(cs_n_out), 7'h01);
    $display("test gating rows done");
    // Power-up: reset held for 512 ticks after supply returns
    @(posedge clock_in);
    supply_low <= 1'b1;
    step(10);
    check(7'({reset_n, reset_hi, fault_n}), 7'h03);
    @(posedge clock_in);
    supply_low <= 1'b0;
    wait_reset(1'b1, 1200);
    in_range(1015, 1040);
    check(7'(reset_hi), 7'h00);
    wait_reset(1'b0, 3000);
    check(7'(found), 7'h00);
    $display("test power-up and long timeout done");
    // First kick switches to the short timeout, then no more kicks
    kick_once();
    wait_reset(1'b0, 2300);
    in_range(2030, 2075);
    step(2);
    check(7'({fault_n, reset_hi}), 7'h01);
    wait_reset(1'b1, 1200);
    in_range(1015, 1040);
    check(7'(fault_n), 7'h00);
    wait_reset(1'b0, 3000);
    check(7'(found), 7'h00);
    $display("test short expiry done");
    // Regular kicks keep the watchdog quiet; a stuck kick repeats resets
    @(posedge clock_in);
    kick_per <= 16'd1000;
    wait_reset(1'b0, 8000);
    check(7'({found, fault_n}), 7'h01);
    @(posedge clock_in);
    kick_per <= 16'h0000;
    wait_reset(1'b0, 2300);
    in_range(1000, 2075);
    wait_reset(1'b1, 1200);
    in_range(1015, 1040);
    wait_reset(1'b0, 33500);
    in_range(32740, 32800);
    $display("test stuck kick done");
    // Floating kick clears the fault and stops expiries
    wait_reset(1'b1, 1200);
    in_range(1015, 1040);
    @(posedge clock_in);
    kick_float <= 1'b1;
    step(6);
    check(7'(fault_n), 7'h01);
    @(posedge clock_in);
    kick_float <= 1'b0;
    kick_once();
    step(20);
    @(posedge clock_in);
    kick_float <= 1'b1;
    wait_reset(1'b0, 5000);
    check(7'({found, fault_n}), 7'h01);
    $display("test floating kick done");
    // Pin high on the internal oscillator: a kick must not bring the short timeout
    @(posedge clock_in);
    {kick_float, pin_level} <= 2'h1;
    kick_once();
    wait_reset(1'b0, 4200);
    check(7'(found), 7'h00);
    $display("test slow internal timeout done");
    // Supply low mid-run, then backup mode with busy inputs
    @(posedge clock_in);
    {kick_float, cs_n, supply_low} <= 3'h1;
    step(6);
    check(7'({reset_n, fault_n, cs_n_out}), 7'h03);
    @(posedge clock_in);
    {backup, early_warn, kick_per, pin_level} <= {1'b1, 1'b1, 16'd3, 1'b1};
    step(6);
    check(outs, 7'h2D);
    $display("test backup done");
    // External timebase: 512 clocks of the pin for the reset time
    @(posedge clock_in);
    {backup, early_warn, kick_per, src_sel, ext_en} <= {1'b0, 1'b0, 16'h0000, 1'b0, 1'b1};
    step(10);
    @(posedge clock_in);
    supply_low <= 1'b0;
    wait_reset(1'b1, 4500);
    in_range(4080, 4140);
    // One kick moves to the 1024-clock normal timeout of the pin
    kick_once();
    wait_reset(1'b0, 8400);
    in_range(8150, 8230);
    $display("test external timebase done");
    tally_and_finish();
  end
endmodule
